// >>> bench/apb_flash_rom_reader_test.sv
// Purpose: Self-checking bench for the APB flash ROM reader
// Assumes: One wait state per access, clock enable dropped in one scenario
// Notes: Expected bytes follow the model's pattern
`timescale 1ns/1ns
module apb_flash_rom_reader_test;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ce = 1'b1;
    logic pslverr;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] rom_data;
    logic [31:0] prdata;
    logic pready;
    logic [6:0] rom_addr;
    int fail_count = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////
    frm_reader u_frm_reader (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .rom_byte_data_in(rom_data), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rom_byte_address_out(rom_addr));
    frm_rom_model u_frm_rom_model (.addr_in(rom_addr), .data_out(rom_data));
    initial forever #2 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] expect_word(input logic [6:0] n);
        expect_word = {24'h00_0000, {1'b0, n} ^ 8'h5A} << {n[1:0], 3'b000};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Leaves psel up so a following call runs back to back
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] exp);
        int waits;
        waits = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= 32'hFFFF_FFFF;
        @(posedge clock_in);
        penable <= 1'b1;
        do
        begin
            @(posedge clock_in);
            waits++;
        end
        while (pready !== 1'b1 && waits < 8);
        check("wait", 32'(waits), 32'h0000_0002);
        check("prdata", prdata, exp);
        check("rom addr", {25'h000_0000, rom_addr}, {25'h000_0000, a[6:0]});
        check("slverr", {31'h0000_0000, pslverr}, 32'h0000_0000);
        penable <= 1'b0;
    endtask
    task automatic idle;
        psel <= 1'b0;
        @(posedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_map;
        logic [6:0] n;
        for (int i = 0; i < 8; i++)
        begin
            n = (i < 4) ? 7'(i) : 7'(120 + i);
            apb(1'b0, {25'h000_0000, n}, expect_word(n));
        end
        idle;
        $display("test_map done");
    endtask
    task automatic test_alias;
        apb(1'b0, 32'h0000_0F81, expect_word(7'h01));
        apb(1'b0, 32'hFFFF_FFFF, expect_word(7'h7F));
        idle;
        $display("test_alias done");
    endtask
    task automatic test_write;
        apb(1'b1, 32'h0000_0005, 32'h0000_0000);
        apb(1'b0, 32'h8000_0005, expect_word(7'h05));
        idle;
        $display("test_write done");
    endtask
    // Enable drops during the wait state; ready must come late, not lost
    task automatic test_stall;
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= 32'h0000_0009;
        @(posedge clock_in);
        penable <= 1'b1;
        ce <= 1'b0;
        repeat (3) @(posedge clock_in);
        check("stalled ready", {31'h0000_0000, pready}, 32'h0000_0000);
        ce <= 1'b1;
        repeat (2) @(posedge clock_in);
        check("stall ready", {31'h0000_0000, pready}, 32'h0000_0001);
        check("stall prdata", prdata, expect_word(7'h09));
        penable <= 1'b0;
        idle;
        $display("test_stall done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        test_map;
        test_alias;
        test_write;
        test_stall;
        print_verdict;
    end
    // Tests need about 60 cycles; a hang is cut well beyond that
    initial
    begin
        repeat (2000) @(posedge clock_in);
        fail_count++;
        $display("Error watchdog expected done seen hang");
        print_verdict;
    end
endmodule

// >>> bench/frm_rom_model.sv
// Purpose: Behavioural 128-byte flash ROM on the reader's byte port
// Assumes: Read is combinational, settled well within one cycle
// Notes: Fixed pattern, not a real image
`timescale 1ns/1ns
module frm_rom_model
(
    input wire logic [frm_pkg::ROM_ADDR_W-1:0] addr_in,
    output logic [frm_pkg::ROM_DATA_W-1:0] data_out
);
    // Each byte differs so a wrong lane or address cannot pass
    assign data_out = {1'b0, addr_in} ^ 8'h5A;
endmodule

// >>> rtl/frm_lane_steer.sv
// Purpose: Place one ROM byte into its little-endian APB read lane
// Assumes: Lane index is the low two bits of the byte address
// Notes: Purely combinational; other lanes read as zero
`timescale 1ns/1ns
module frm_lane_steer
(
    input wire logic [frm_pkg::ROM_DATA_W-1:0] byte_in,
    input wire logic [frm_pkg::LANE_W-1:0] lane_in,
    output logic [frm_pkg::APB_DATA_W-1:0] word_out
);
    always_comb
    begin
        word_out = '0;
        unique case (lane_in)
            2'h0: word_out[7:0] = byte_in;
            2'h1: word_out[15:8] = byte_in;
            2'h2: word_out[23:16] = byte_in;
            2'h3: word_out[31:24] = byte_in;
        endcase
    end
endmodule

// >>> rtl/frm_pkg.sv
// Purpose: Shared constants for the APB flash ROM byte reader
// Assumes: 32-bit APB data, 128-byte ROM behind a 7-bit byte address
// Notes: Constants only
package frm_pkg;
    localparam int unsigned ROM_ADDR_W = 7;
    localparam int unsigned ROM_DATA_W = 8;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned APB_ADDR_W = 32;
    localparam int unsigned LANE_W = 2;
    localparam int unsigned LANE_LSB = 0;
    localparam int unsigned ROM_BYTES = 128;
    localparam logic [APB_DATA_W-1:0] PRDATA_RESET = 32'h0000_0000;
    localparam logic [ROM_ADDR_W-1:0] ROM_ADDR_RESET = 7'h00;
    localparam logic [ROM_ADDR_W-1:0] ROM_BASE_BYTE = 7'h00;
endpackage

// >>> rtl/frm_reader.sv
// Purpose: APB slave giving read-only byte access to a 128-byte flash ROM
// Assumes: ROM instance on the same clock, data valid one cycle after address
// Notes: Every access takes one wait state; writes complete and do nothing
// Functional notes
// - APB slave exposing all 128 ROM bytes
// - First ROM byte sits at slot base
// - ROM image aliases across whole slot
// - Writes never change ROM contents
// - Each access returns one byte only
// - Drive 7-bit byte address to ROM
// - Byte n read at byte address n, in lane n%4
`timescale 1ns/1ns
module frm_reader
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [frm_pkg::APB_ADDR_W-1:0] paddr_in,
    input wire logic [frm_pkg::APB_DATA_W-1:0] pwdata_in,
    input wire logic [frm_pkg::ROM_DATA_W-1:0] rom_byte_data_in,
    output logic [frm_pkg::APB_DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic [frm_pkg::ROM_ADDR_W-1:0] rom_byte_address_out
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        FRM_IDLE = 3'b001,
        FRM_FETCH = 3'b010,
        FRM_DONE = 3'b100
    } frm_state_e;

    typedef struct packed
    {
        frm_state_e state;
        logic is_write;
        logic [frm_pkg::ROM_ADDR_W-1:0] rom_addr;
        logic [frm_pkg::APB_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } frm_regs_s;

    frm_regs_s cur;
    frm_regs_s next_cur;
    logic [frm_pkg::APB_DATA_W-1:0] steered;
    logic unused_wdata;

    // Write data is never stored; the ROM cannot be altered from the bus
    assign unused_wdata = ^pwdata_in;

    frm_lane_steer u_frm_lane_steer
    (
        .byte_in(rom_byte_data_in),
        .lane_in(cur.rom_addr[frm_pkg::LANE_W-1:frm_pkg::LANE_LSB]),
        .word_out(steered)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        // No access is ever in error; the whole slot is mapped
        next_cur.pslverr = 1'b0;
        unique case (cur.state)
            FRM_IDLE:
            begin
                next_cur.pready = 1'b0;
                if (psel_in && !penable_in)
                begin
                    // Upper address bits are dropped, so the image repeats
                    next_cur.rom_addr = paddr_in[frm_pkg::ROM_ADDR_W-1:0];
                    next_cur.is_write = pwrite_in;
                    next_cur.state = FRM_FETCH;
                end
            end
            FRM_FETCH:
            begin
                // Wait state gives the ROM a full cycle to answer
                // A setup seen here is ignored; the master is still waiting
                if (cur.is_write)
                begin
                    next_cur.prdata = frm_pkg::PRDATA_RESET;
                end
                else
                begin
                    next_cur.prdata = steered;
                end
                next_cur.pready = 1'b1;
                next_cur.state = FRM_DONE;
            end
            FRM_DONE:
            begin
                next_cur.pready = 1'b0;
                next_cur.state = FRM_IDLE;
            end
            // Illegal codes fall back to idle so an upset cannot hang the bus
            default:
            begin
                next_cur.pready = 1'b0;
                next_cur.state = FRM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cur.state <= FRM_IDLE;
            cur.is_write <= 1'b0;
            cur.rom_addr <= frm_pkg::ROM_ADDR_RESET;
            cur.prdata <= frm_pkg::PRDATA_RESET;
            cur.pready <= 1'b0;
            cur.pslverr <= 1'b0;
        end
        else if (ce_in)
        begin
            cur <= next_cur;
        end
    end

    assign prdata_out = cur.prdata;
    assign pready_out = cur.pready;
    assign rom_byte_address_out = cur.rom_addr;
    assign pslverr_out = cur.pslverr;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    AST_ADDR_LOW_BITS: assert property (
        (cur.state == FRM_IDLE && psel_in && !penable_in && ce_in)
        |=> rom_byte_address_out == $past(paddr_in[6:0]))
        else $error("ROM address not taken from low seven bits");

    AST_ALIAS: assert property (
        (cur.state == FRM_IDLE && psel_in && !penable_in && ce_in && paddr_in[7])
        |=> rom_byte_address_out == $past(paddr_in[6:0]))
        else $error("High address bits leaked into ROM address");

    AST_READ_LANE: assert property (
        (cur.state == FRM_FETCH && !cur.is_write && ce_in)
        |=> prdata_out == ({24'h00_0000, $past(rom_byte_data_in)}
                           << {$past(rom_byte_address_out[1:0]), 3'b000}))
        else $error("ROM byte not placed in its lane");

    AST_ONE_BYTE: assert property (
        pready_out |-> (prdata_out & ~(32'h0000_00ff << {rom_byte_address_out[1:0], 3'b000}))
                       == 32'h0000_0000)
        else $error("More than one byte lane driven");

    AST_WRITE_NO_DATA: assert property (
        (pready_out && cur.is_write) |-> prdata_out == 32'h0000_0000)
        else $error("Write returned data");

    AST_BASE_BYTE: assert property (
        (pready_out && !cur.is_write && rom_byte_address_out == frm_pkg::ROM_BASE_BYTE)
        |-> prdata_out == {24'h00_0000, $past(rom_byte_data_in)})
        else $error("Slot base does not return byte zero in lane zero");

    AST_READY_TIMING: assert property (
        (cur.state == FRM_IDLE && psel_in && !penable_in && ce_in) ##1 ce_in
        |=> pready_out)
        else $error("Ready not given after one wait state");

    AST_READY_PULSE: assert property (
        (pready_out && ce_in) |=> !pready_out)
        else $error("Ready stood for more than one enabled cycle");

    AST_READY_ONLY_DONE: assert property (
        pready_out |-> cur.state == FRM_DONE)
        else $error("Ready raised outside the completion state");

    AST_NO_ERROR: assert property (
        !pslverr_out)
        else $error("Slave error raised on a mapped slot");

    // Freeze check covers three of the four outputs (not pslverr_out), so a stall cannot lose a byte
    AST_CE_FREEZE: assert property (
        !ce_in |=> $stable(prdata_out) && $stable(pready_out)
                   && $stable(rom_byte_address_out))
        else $error("State moved while clock enable was low");

    AST_FETCH_TO_DONE: assert property (
        (cur.state == FRM_FETCH && ce_in) |=> cur.state == FRM_DONE)
        else $error("Fetch did not complete in one enabled cycle");

    AST_DONE_TO_IDLE: assert property (
        (cur.state == FRM_DONE && ce_in) |=> cur.state == FRM_IDLE)
        else $error("Completion did not return to idle");

    AST_IDLE_PRDATA_HOLDS: assert property (
        (cur.state == FRM_IDLE) |=> $stable(prdata_out))
        else $error("Read data changed outside a fetch");

    AST_FETCH_KEEPS_KIND: assert property (
        (cur.state == FRM_FETCH) |=> $stable(cur.is_write))
        else $error("Transfer direction changed during fetch");

    // Checked from the edge after the setup, when the new address has settled
    AST_ADDR_HELD: assert property (
        (cur.state != FRM_IDLE) |=> $stable(rom_byte_address_out))
        else $error("ROM address changed during transfer");

    ////////////////////////////////////////////////////////////////////////////////
    CV_READ: cover property (pready_out && !cur.is_write);
    CV_WRITE: cover property (pready_out && cur.is_write);
    CV_TOP_BYTE: cover property (pready_out && rom_byte_address_out == 7'h7f);
    CV_STALL: cover property (cur.state == FRM_FETCH && !ce_in);
    CV_BACK_TO_BACK: cover property (
        pready_out ##1 (cur.state == FRM_IDLE && psel_in && !penable_in));
endmodule
